// file: hdl/usd_defines.svh
// Purpose: Offsets, field positions and counts of the serial port
// Assumes: Byte wide register port, 3 bit address
// Notes:   Included by the design files
`ifndef USD_DEFINES_SVH
`define USD_DEFINES_SVH
// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define USD_ADR_CTRL_A  3'h0
`define USD_ADR_CTRL_B  3'h1
`define USD_ADR_CTRL_C  3'h2
`define USD_ADR_DATA    3'h3
`define USD_ADR_BAUD_LO 3'h4
`define USD_ADR_BAUD_HI 3'h5
// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define USD_A_RXC   7
`define USD_A_TXC   6
`define USD_A_DRE   5
`define USD_A_DBL   1
`define USD_B_RXCIE 7
`define USD_B_TX_DONE_IRQ_ON 6
`define USD_B_DREIE 5
`define USD_B_RECEIVER_ON  4
`define USD_B_TRANSMITTER_ON  3
`define USD_B_CSZ2  2
`define USD_B_RXB8  1
`define USD_B_TX_NINTH_BIT  0
// --------------------------------------------------------------
// Reset values and counts
// --------------------------------------------------------------
`define USD_RST_BYTE 8'h00
`define USD_RST_BAUD 12'h000
`define USD_CSZ_NINE 3'h7
`define USD_OS_LAST_N 4'hF
`define USD_OS_LAST_D 4'h7
`define USD_OS_MID_N  4'h7
`define USD_OS_MID_D  4'h3
`endif

// file: hdl/usd_pkg.sv
// Purpose: Types shared by the serial port files
// Assumes: Nothing
// Notes:   Constants live in usd_defines.svh
package usd_pkg;
    // --------------------------------------------------------------
    // Modes and carriers
    // --------------------------------------------------------------
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} usd_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} usd_rx_e;
    typedef struct packed {
        logic        master;
        logic        sync;
        logic        par_on;
        logic        par_odd;
        logic        two_stop;
        logic [2:0]  csz;
        logic        pol;
        logic        dbl;
        logic [11:0] baud;
    } usd_cfg_s;
    typedef struct packed {
        logic os;
        logic tx;
        logic rx;
    } usd_tick_s;
endpackage

// file: hdl/usd_sync.sv
// Purpose: Two stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes:   Stage one feeds stage two only
module usd_sync
    import usd_pkg::*;
#(
    parameter int W = 2
)
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } usd_sync_s;
    usd_sync_s s_ff;
    usd_sync_s nxt_s;
    always_comb
    begin
        nxt_s.meta = d;
        nxt_s.stab = s_ff.meta;
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s_ff <= '1;
        else
            s_ff <= nxt_s;
    end
    assign q = s_ff.stab;
endmodule // usd_sync

// file: hdl/usd_clkgen.sv
// Purpose: Baud divider, serial clock master and edge finder
// Assumes: xck_lvl already synchronised
// Notes:   All rates are one cycle enables
`include "usd_defines.svh"
module usd_clkgen
    import usd_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rstn,
    input  wire usd_cfg_s  cfg,
    input  wire logic      run,
    input  wire logic      xck_lvl,
    output      usd_tick_s tk,
    output      logic      xck_o
);
    typedef struct packed {
        logic [11:0] div;
        logic [3:0]  os;
        logic        serial_clock_pin;
        logic        xck_prev;
    } usd_cg_s;
    usd_cg_s s_ff;
    usd_cg_s nxt_s;
    logic    div_tick;
    logic    rise;
    logic    fall;
    logic [3:0] os_last;
    always_comb
    begin
        nxt_s    = s_ff;
        tk       = '0;
        div_tick = run && (s_ff.div == cfg.baud);
        os_last  = cfg.dbl ? `USD_OS_LAST_D : `USD_OS_LAST_N;
        nxt_s.xck_prev = xck_lvl;
        if (!run || div_tick)
            nxt_s.div = '0;
        else
            nxt_s.div = s_ff.div + 12'h001;
        if (cfg.sync && cfg.master)
        begin
            rise = div_tick && !s_ff.serial_clock_pin;
            fall = div_tick && s_ff.serial_clock_pin;
        end
        else
        begin
            rise = xck_lvl && !s_ff.xck_prev;
            fall = !xck_lvl && s_ff.xck_prev;
        end
        if (cfg.sync && cfg.master && div_tick)
            nxt_s.serial_clock_pin = !s_ff.serial_clock_pin;
        if (!cfg.sync)
        begin
            tk.os = div_tick;
            if (div_tick)
            begin
                nxt_s.os = (s_ff.os >= os_last) ? 4'h0 : s_ff.os + 4'h1;
                tk.tx = (s_ff.os >= os_last);
            end
        end
        else
        begin
            tk.tx = run && (cfg.pol ? fall : rise);
            tk.rx = run && (cfg.pol ? rise : fall);
        end
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end
    assign xck_o = s_ff.serial_clock_pin;
endmodule // usd_clkgen

// file: hdl/usd_top.sv
// Purpose: Serial port transmitter and receiver datapath
// Assumes: Byte register port, pins asynchronous to CLK
// Notes:   Single entry receive buffer
//
// The strobed register port and the register offsets were chosen for this implementation.
`include "usd_defines.svh"
module usd_top
    import usd_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic [2:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output      logic [7:0] RDATA,
    input  wire logic       GIE,
    input  wire logic       TXC_ACK,
    input  wire logic       RXD_I,
    input  wire logic       XCK_I,
    output      logic       TXD_O,
    output      logic       TXD_OE,
    output      logic       RXD_TAKEN,
    output      logic       XCK_O,
    output      logic       XCK_OE,
    output      logic       DRE_IRQ,
    output      logic       TXC_IRQ,
    output      logic       RXC_IRQ
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic        rxcie;
        logic        tx_done_irq_on;
        logic        tx_buffer_empty_irq_on;
        logic        receiver_on;
        logic        transmitter_on;
        logic        csz2;
        logic        tx_ninth_bit;
        logic        double_speed_bit;
        logic [7:0]  ctrl_c;
        logic [11:0] baud_divisor;
        logic [8:0]  tx_buf;
        logic        tx_buffer_empty_flag;
        logic        tx_done_flag;
        logic        oe;
        usd_tx_e     tx_st;
        logic [12:0] tx_frame;
        logic [3:0]  tx_left;
        logic        txd;
        usd_rx_e     rx_st;
        logic [3:0]  rx_cnt;
        logic [3:0]  rx_idx;
        logic [8:0]  rx_sh;
        logic [8:0]  rx_buf;
        logic        rx_done_flag;
        logic [7:0]  rdata;
    } usd_core_s;
    usd_core_s  s_ff;
    usd_core_s  nxt_s;
    usd_cfg_s   cfg;
    usd_tick_s  tk;
    logic [1:0] pins_sync;
    logic       rxd;
    logic [3:0] nbits;
    logic [3:0] os_mid;
    logic       smp;
    logic       load_ok;
    logic       tx_load;
    logic       tx_end;
    logic       txc_set;
    logic       rx_stop;
    logic       wr_data;
    logic [12:0] frame;
    logic [3:0]  flen;
    // --------------------------------------------------------------
    // Pin synchronisers and clock generator
    // --------------------------------------------------------------
    usd_sync #(.W(2)) u_sync
    (
        .clk  (CLK),
        .rstn (RSTN),
        .d    ({RXD_I, XCK_I}),
        .q    (pins_sync)
    );
    assign rxd = pins_sync[1];
    usd_clkgen u_clkgen
    (
        .clk     (CLK),
        .rstn    (RSTN),
        .cfg     (cfg),
        .run     (s_ff.oe || s_ff.receiver_on),
        .xck_lvl (pins_sync[0]),
        .tk      (tk),
        .xck_o   (XCK_O)
    );
    always_comb
    begin
        cfg.master   = s_ff.ctrl_c[7];
        cfg.sync     = s_ff.ctrl_c[6];
        cfg.par_on   = s_ff.ctrl_c[5];
        cfg.par_odd  = s_ff.ctrl_c[4];
        cfg.two_stop = s_ff.ctrl_c[3];
        cfg.csz      = {s_ff.csz2, s_ff.ctrl_c[2:1]};
        cfg.pol      = s_ff.ctrl_c[0];
        cfg.dbl      = s_ff.double_speed_bit;
        cfg.baud     = s_ff.baud_divisor;
    end
    // --------------------------------------------------------------
    // Frame builder
    // --------------------------------------------------------------
    function automatic logic [12:0] build(input logic [8:0] d,
                                          input logic [3:0] n,
                                          input usd_cfg_s c);
        logic [12:0] f;
        logic        p;
        f = '1;
        p = c.par_odd;
        // start bit then data LSB first
        f[0] = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            if (i < n)
            begin
                f[i+1] = d[i];
                p = p ^ d[i];
            end
        end
        if (c.par_on)
            f[n+4'h1] = p;
        return f;
    endfunction
    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb
    begin
        nxt_s   = s_ff;
        nbits   = (cfg.csz == `USD_CSZ_NINE) ? 4'h9
                : {2'b00, cfg.csz[1:0]} + 4'h5;
        os_mid  = cfg.dbl ? `USD_OS_MID_D : `USD_OS_MID_N;
        frame   = build(s_ff.tx_buf, nbits, cfg);
        flen    = nbits + {3'b000, cfg.par_on}
                + {3'b000, cfg.two_stop} + 4'h1;
        wr_data = WR && (ADDR == `USD_ADR_DATA);
        nxt_s.oe = s_ff.transmitter_on
                 || (s_ff.oe && (s_ff.tx_st == TX_SHIFT
                 || !s_ff.tx_buffer_empty_flag));
        load_ok = s_ff.oe && !s_ff.tx_buffer_empty_flag;
        tx_end  = tk.tx && s_ff.tx_st == TX_SHIFT
                && s_ff.tx_left == 4'h0;
        // load when idle or after last stop
        tx_load = tk.tx && load_ok
                && (s_ff.tx_st == TX_IDLE || tx_end);
        txc_set = tx_end && !load_ok;
        if (tx_load)
        begin
            nxt_s.tx_st    = TX_SHIFT;
            nxt_s.txd      = frame[0];
            nxt_s.tx_frame = {1'b1, frame[12:1]};
            nxt_s.tx_left  = flen;
            nxt_s.tx_buffer_empty_flag = 1'b1;
        end
        else if (tx_end)
        begin
            nxt_s.tx_st = TX_IDLE;
            nxt_s.txd   = 1'b1;
        end
        else if (tk.tx && s_ff.tx_st == TX_SHIFT)
        begin
            nxt_s.txd      = s_ff.tx_frame[0];
            nxt_s.tx_frame = {1'b1, s_ff.tx_frame[12:1]};
            nxt_s.tx_left  = s_ff.tx_left - 4'h1;
        end
        if (wr_data)
        begin
            nxt_s.tx_buf = {s_ff.tx_ninth_bit, WDATA};
            nxt_s.tx_buffer_empty_flag = 1'b0;
        end
        if (TXC_ACK || (WR && ADDR == `USD_ADR_CTRL_A
            && WDATA[`USD_A_TXC]))
            nxt_s.tx_done_flag = 1'b0;
        if (txc_set)
            nxt_s.tx_done_flag = 1'b1;
        smp = cfg.sync ? tk.rx
            : (tk.os && s_ff.rx_cnt == (cfg.dbl ? `USD_OS_LAST_D
                                                : `USD_OS_LAST_N));
        rx_stop = 1'b0;
        case (s_ff.rx_st)
            RX_IDLE:
            begin
                if (s_ff.receiver_on && !rxd)
                begin
                    nxt_s.rx_sh  = '0;
                    nxt_s.rx_idx = 4'h0;
                    nxt_s.rx_cnt = 4'h0;
                    if (cfg.sync && tk.rx)
                        nxt_s.rx_st = RX_DATA;
                    else if (!cfg.sync && tk.os)
                        nxt_s.rx_st = RX_START;
                end
            end
            RX_START:
            begin
                if (tk.os)
                begin
                    nxt_s.rx_cnt = s_ff.rx_cnt + 4'h1;
                    if (s_ff.rx_cnt == os_mid)
                    begin
                        nxt_s.rx_cnt = 4'h0;
                        nxt_s.rx_st  = rxd ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA:
            begin
                if (tk.os)
                    nxt_s.rx_cnt = smp ? 4'h0 : s_ff.rx_cnt + 4'h1;
                if (smp)
                begin
                    nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
                    if (s_ff.rx_idx < nbits)
                        nxt_s.rx_sh[s_ff.rx_idx] = rxd;
                    if (s_ff.rx_idx == nbits + {3'b000, cfg.par_on})
                    begin
                        rx_stop     = 1'b1;
                        nxt_s.rx_st = RX_IDLE;
                    end
                end
            end
            default:
                nxt_s.rx_st = RX_IDLE;
        endcase
        if (RD && ADDR == `USD_ADR_DATA)
            nxt_s.rx_done_flag = 1'b0;
        if (rx_stop)
        begin
            nxt_s.rx_buf       = s_ff.rx_sh;
            nxt_s.rx_done_flag = 1'b1;
        end
        if (!s_ff.receiver_on)
        begin
            nxt_s.rx_st        = RX_IDLE;
            nxt_s.rx_done_flag = 1'b0;
        end
        // --------------------------------------------------------------
        // Register writes and reads
        // --------------------------------------------------------------
        if (WR)
        begin
            case (ADDR)
                `USD_ADR_CTRL_A:
                    nxt_s.double_speed_bit = WDATA[`USD_A_DBL];
                `USD_ADR_CTRL_B:
                begin
                    nxt_s.rxcie          = WDATA[`USD_B_RXCIE];
                    nxt_s.tx_done_irq_on          = WDATA[`USD_B_TX_DONE_IRQ_ON];
                    nxt_s.tx_buffer_empty_irq_on          = WDATA[`USD_B_DREIE];
                    nxt_s.receiver_on    = WDATA[`USD_B_RECEIVER_ON];
                    nxt_s.transmitter_on = WDATA[`USD_B_TRANSMITTER_ON];
                    nxt_s.csz2           = WDATA[`USD_B_CSZ2];
                    nxt_s.tx_ninth_bit   = WDATA[`USD_B_TX_NINTH_BIT];
                end
                `USD_ADR_CTRL_C:
                    nxt_s.ctrl_c = WDATA;
                `USD_ADR_BAUD_LO:
                    nxt_s.baud_divisor[7:0] = WDATA;
                `USD_ADR_BAUD_HI:
                    nxt_s.baud_divisor[11:8] = WDATA[3:0];
                default:
                    nxt_s.ctrl_c = s_ff.ctrl_c;
            endcase
        end
        nxt_s.rdata = `USD_RST_BYTE;
        if (RD)
        begin
            case (ADDR)
                `USD_ADR_CTRL_A:
                    nxt_s.rdata = {s_ff.rx_done_flag, s_ff.tx_done_flag,
                                   s_ff.tx_buffer_empty_flag, 3'b000,
                                   s_ff.double_speed_bit, 1'b0};
                `USD_ADR_CTRL_B:
                    nxt_s.rdata = {s_ff.rxcie, s_ff.tx_done_irq_on, s_ff.tx_buffer_empty_irq_on,
                                   s_ff.receiver_on, s_ff.transmitter_on,
                                   s_ff.csz2, s_ff.rx_buf[8],
                                   s_ff.tx_ninth_bit};
                `USD_ADR_CTRL_C:
                    nxt_s.rdata = s_ff.ctrl_c;
                // stored frame already zero above size
                `USD_ADR_DATA:
                    nxt_s.rdata = s_ff.rx_buf[7:0];
                `USD_ADR_BAUD_LO:
                    nxt_s.rdata = s_ff.baud_divisor[7:0];
                `USD_ADR_BAUD_HI:
                    nxt_s.rdata = {4'h0, s_ff.baud_divisor[11:8]};
                default:
                    nxt_s.rdata = `USD_RST_BYTE;
            endcase
        end
    end
    // --------------------------------------------------------------
    // Registers and outputs
    // --------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s_ff       <= '0;
            s_ff.txd   <= 1'b1;
            s_ff.tx_buffer_empty_flag <= 1'b1;
            s_ff.tx_st <= TX_IDLE;
            s_ff.rx_st <= RX_IDLE;
        end
        else
            s_ff <= nxt_s;
    end
    assign RDATA     = s_ff.rdata;
    assign TXD_O     = s_ff.txd;
    assign TXD_OE    = s_ff.oe;
    assign RXD_TAKEN = s_ff.receiver_on;
    assign XCK_OE    = cfg.sync && cfg.master
                     && (s_ff.oe || s_ff.receiver_on);
    assign DRE_IRQ   = GIE && s_ff.tx_buffer_empty_irq_on && s_ff.tx_buffer_empty_flag;
    assign TXC_IRQ   = GIE && s_ff.tx_done_irq_on && s_ff.tx_done_flag;
    assign RXC_IRQ   = GIE && s_ff.rxcie && s_ff.rx_done_flag;
    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_load;
        tx_load;
    endsequence
    sequence s_start_out;
        !TXD_O ##1 !TXD_O;
    endsequence
    pin_take_a: assert property (s_ff.transmitter_on |=> TXD_OE)
        else $error("transmit pin not taken");
    start_low_a: assert property (s_load |=> s_start_out or !TXD_O)
        else $error("start bit not low");
    dre_clear_a: assert property (wr_data |=> !s_ff.tx_buffer_empty_flag)
        else $error("empty flag not cleared by write");
    load_empty_a: assert property (s_load and !wr_data |=> DRE_IRQ || !GIE
        || !s_ff.tx_buffer_empty_irq_on)
        else $error("empty request missing after load");
    txc_set_a: assert property (txc_set |=> s_ff.tx_done_flag ##0 TXD_O)
        else $error("done flag not set");
    txc_clr_a: assert property (TXC_ACK && !txc_set |=> !s_ff.tx_done_flag)
        else $error("done flag not cleared");
    release_a: assert property ($fell(TXD_OE) |-> $past(s_ff.tx_st) == TX_IDLE
        && $past(s_ff.tx_buffer_empty_flag))
        else $error("pin released while busy");
    idle_high_a: assert property (TXD_OE && s_ff.tx_st == TX_IDLE |-> TXD_O)
        else $error("idle line not high");
    rx_store_a: assert property (rx_stop && s_ff.receiver_on |=>
        s_ff.rx_done_flag && s_ff.rx_buf == $past(s_ff.rx_sh))
        else $error("frame not stored");
    rx_flush_a: assert property (!s_ff.receiver_on |=> !s_ff.rx_done_flag)
        else $error("receive flag not flushed");
endmodule // usd_top

// file: tb/usd_peer_model.sv
// Purpose: Remote serial peer on the data and clock lines
// Assumes: Async bit time set by bit_ns, sync clock 800 ns
// Notes:   Receive line idles high, clock stands low
module usd_peer_model
    import usd_pkg::*;
(
    input  wire logic txd,
    input  wire logic txd_oe,
    output      logic rxd,
    output      logic serial_clock_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int          bit_ns = 1600;
    int          nbits  = 9;
    logic [11:0] got;
    logic [11:0] q[$];
    initial
    begin
        rxd = 1'b1;
        serial_clock_pin = 1'b0;
    end
    always
    begin
        @(negedge txd);
        if (txd_oe === 1'b1)
        begin
            got = '1;
            #(bit_ns / 2);
            for (int i = 0; i < nbits; i++)
            begin
                #(bit_ns);
                got[i] = txd;
            end
            q.push_back(got);
        end
    end
    task automatic send(input logic [12:0] f, input int n, input logic sy);
        for (int i = 0; i < n; i++)
        begin
            if (sy)
            begin
                serial_clock_pin = 1'b1;
                rxd = f[i];
                #400;
                serial_clock_pin = 1'b0;
                #400;
            end
            else
            begin
                rxd = f[i];
                #(bit_ns);
            end
        end
        rxd = 1'b1;
    endtask
endmodule // usd_peer_model

// file: tb/usd_top_tb_top.sv
// Purpose: Register driven checks of the serial datapath
// Assumes: Baud divisor zero, async bit time 16 clocks, 8 at double speed
// Notes:   Peer model captures and sends frames
`include "usd_defines.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module usd_top_tb_top
    import usd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 0, RSTN = 0, WR = 0, RD = 0, GIE = 1, TXC_ACK = 0;
    logic [2:0]  ADDR = 0;
    logic [7:0]  WDATA = 0, RDATA, r, m;
    logic TXD_O, TXD_OE, RXD_TAKEN, XCK_O, XCK_OE, RXD_I, XCK_I;
    logic DRE_IRQ, TXC_IRQ, RXC_IRQ;
    logic [2:0]  cz[5] = '{0, 1, 2, 3, 7};
    logic        pn[5] = '{1, 1, 0, 1, 1};
    logic        po[5] = '{0, 1, 0, 1, 0};
    logic [8:0]  dt[5] = '{9'h0FF, 9'h0C3, 9'h0A5, 9'h03C, 9'h15A};
    logic [8:0]  d;
    logic [11:0] w, w2;
    int          fails = 0, n_compared = 0, nd, nb;
    initial forever #50 CLK = ~CLK;
    usd_top uut (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .GIE(GIE), .TXC_ACK(TXC_ACK),
        .RXD_I(RXD_I), .XCK_I(XCK_I), .TXD_O(TXD_O), .TXD_OE(TXD_OE),
        .RXD_TAKEN(RXD_TAKEN), .XCK_O(XCK_O), .XCK_OE(XCK_OE),
        .DRE_IRQ(DRE_IRQ), .TXC_IRQ(TXC_IRQ), .RXC_IRQ(RXC_IRQ));
    usd_peer_model peer (.txd(TXD_O), .txd_oe(TXD_OE), .rxd(RXD_I),
        .serial_clock_pin(XCK_I));
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge CLK); ADDR <= a; WDATA <= v; WR <= 1'b1;
        @(posedge CLK); WR <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge CLK); ADDR <= a; RD <= 1'b1;
        @(posedge CLK); RD <= 1'b0;
        @(negedge CLK); v = RDATA;
    endtask
    task automatic poll(input logic [2:0] a, input int b, input logic v);
        logic [7:0] x;
        for (int i = 0; i < 1000; i++)
        begin
            rd(a, x);
            if (x[b] === v) break;
        end
        `CHK("poll", v, x[b])
    endtask
    task automatic wait_q(input int n);
        for (int i = 0; i < 900 && peer.q.size() < n; i++) @(posedge CLK);
        `CHK("frames", n, peer.q.size())
    endtask
    function automatic logic [11:0] txw(input logic [8:0] x, input int n,
        input logic pon, input logic podd, output int k);
        logic [11:0] v;
        logic        p;
        v = '1;
        p = podd;
        for (k = 0; k < n; k++)
        begin
            v[k] = x[k];
            p ^= x[k];
        end
        if (pon) v[k++] = p;
        k++;
        return v;
    endfunction
    task automatic give_verdict();
        if (fails == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #5_000_000;
        fails++;
        give_verdict();
    end
    initial
    begin
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        rd(`USD_ADR_CTRL_A, r); `CHK("ctrl_a", 8'h20, r)
        `CHK("txd_oe", 1'b0, TXD_OE)
        rd(3'h6, r); `CHK("unmapped", 8'h00, r)
        wr(`USD_ADR_BAUD_LO, 8'h00);
        wr(`USD_ADR_BAUD_HI, 8'h00);
        for (int c = 0; c < 5; c++)
        begin
            d = dt[c];
            nd = (cz[c] == 3'h7) ? 9 : int'(cz[c]) + 5;
            w2 = txw({d[8], ~d[7:0]}, nd, pn[c], po[c], nb);
            w = txw(d, nd, pn[c], po[c], nb);
            peer.nbits = (c == 2) ? nb + 1 : nb;
            peer.bit_ns = (c == 1) ? 800 : 1600;
            peer.q.delete();
            wr(`USD_ADR_CTRL_A, {6'h00, 1'(c == 1), 1'b0});
            wr(`USD_ADR_CTRL_C, {2'b00, pn[c], po[c], 1'(c == 2),
                cz[c][1:0], 1'b0});
            wr(`USD_ADR_CTRL_B, {5'b11111, cz[c][2], 1'b0, d[8]});
            repeat (2) @(negedge CLK);
            `CHK("txd_oe", 1'b1, TXD_OE)
            `CHK("rxd_taken", 1'b1, RXD_TAKEN)
            `CHK("txd idle", 1'b1, TXD_O)
            wr(`USD_ADR_DATA, d[7:0]);
            poll(`USD_ADR_CTRL_A, 5, 1'b1);
            wr(`USD_ADR_DATA, ~d[7:0]);
            rd(`USD_ADR_CTRL_A, r); `CHK("dre", 1'b0, r[5])
            `CHK("dre irq", 1'b0, DRE_IRQ)
            wait_q(2);
            `CHK("frame a", w, peer.q[0])
            `CHK("frame b", w2, peer.q[1])
            poll(`USD_ADR_CTRL_A, 6, 1'b1);
            `CHK("txc irq", 1'b1, TXC_IRQ)
            `CHK("dre irq", 1'b1, DRE_IRQ)
            if (c % 2)
            begin
                @(posedge CLK); TXC_ACK <= 1'b1;
                @(posedge CLK); TXC_ACK <= 1'b0;
            end
            else wr(`USD_ADR_CTRL_A, 8'h40);
            rd(`USD_ADR_CTRL_A, r); `CHK("txc clr", 1'b0, r[6])
            peer.send({w, 1'b0}, nb + 2, 1'b0);
            poll(`USD_ADR_CTRL_A, 7, 1'b1);
            `CHK("rxc irq", 1'b1, RXC_IRQ)
            m = (nd > 8) ? 8'hFF : 8'hFF >> (8 - nd);
            rd(`USD_ADR_CTRL_B, r);
            if (nd == 9) `CHK("rx ninth", d[8], r[1])
            rd(`USD_ADR_DATA, r); `CHK("rx data", d[7:0] & m, r)
            rd(`USD_ADR_CTRL_A, r); `CHK("rxc", 1'b0, r[7])
        end
        peer.q.delete();
        wr(`USD_ADR_DATA, 8'h81);
        wr(`USD_ADR_CTRL_B, 8'h14);
        repeat (2) @(negedge CLK);
        `CHK("oe hold", 1'b1, TXD_OE)
        wait_q(1);
        w = txw(9'h181, 9, 1'b1, 1'b0, nb);
        `CHK("last frame", w, peer.q[0])
        poll(`USD_ADR_CTRL_A, 6, 1'b1);
        repeat (4) @(negedge CLK);
        `CHK("oe free", 1'b0, TXD_OE)
        wr(`USD_ADR_CTRL_B, 8'h10);
        wr(`USD_ADR_CTRL_C, 8'h46);
        peer.send({3'b111, 1'b1, 8'h96, 1'b0}, 11, 1'b1);
        poll(`USD_ADR_CTRL_A, 7, 1'b1);
        rd(`USD_ADR_DATA, r); `CHK("sync rx", 8'h96, r)
        `CHK("xck_oe slave", 1'b0, XCK_OE)
        w = txw(9'h03A, 8, 1'b0, 1'b0, nb);
        peer.nbits = nb;
        peer.bit_ns = 200;
        peer.q.delete();
        wr(`USD_ADR_CTRL_C, 8'hC7);
        wr(`USD_ADR_CTRL_B, 8'h18);
        repeat (2) @(negedge CLK);
        `CHK("xck_oe master", 1'b1, XCK_OE)
        r[0] = XCK_O;
        @(negedge CLK);
        `CHK("xck_o", ~r[0], XCK_O)
        wr(`USD_ADR_DATA, 8'h3A);
        wait_q(1);
        `CHK("sync frame", w, peer.q[0])
        give_verdict();
    end
endmodule // usd_top_tb_top
